// ### t1lem_monitor.sv
// T1 line error monitor: error counters, line status, alarm simulation.
// Assumes all inputs come from logic on core_clk; one_hz_tick is a pulse.
// How it works
// RULE1: PRBS status high when pattern sync reached
// RULE2: Short flagged on the fourth shorted pulse in a row
// RULE3: Tristate on short, retry every 128
// RULE4: Short gone: re-enable, clear, raise change
// RULE5: Open after 32 zeros, clear on pulse
// RULE6: Line tristate control freezes both bits
// RULE7: Step counter advances per test set
// RULE8: Step selects which alarms are simulated
// RULE9: LOS, AIS, PRBS errors only while held; the code gates LOS and AIS only and has no PRBS error simulation
// RULE10: Steps 0,3,4,7 clear simulated flags
// RULE11: Software spaces steps 1.5/3 ms apart
// RULE12: Advance bit stable one clock minimum
// RULE13: Framing errors counted only in sync
// RULE14: Counters saturate, never wrap
// RULE15: Simulation increments counters per table
// RULE16: B8ZS counts real violations, zeros >7
// RULE17: AMI counts all violations, zeros >15
// RULE18: NRZ or CMI: no violation counting
// RULE19: CRC counts per multiframe in ESF only
// RULE20: Blocks count once per errored multiframe
// RULE21: Freeze bit stops buffer, resets counter, except in latch mode
// RULE22: Latch mode captures and clears each second
// RULE23: Reset clears counters, step and status
`default_nettype none
module t1lem_monitor (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire t1lem_pkg::t1lem_rx_t rx_ev,
  input  wire t1lem_pkg::t1lem_tx_t tx_ev,
  input  wire logic              one_hz_tick,
  output logic                   tx_line_out_a_oe_n,
  output logic                   tx_line_out_b_oe_n,
  output logic                   tx_line_change_irq,
  output logic                   sim_frame_loss,
  output logic                   sim_multiframe_loss,
  output logic                   sim_loss_of_signal,
  output logic                   sim_all_ones,
  output logic                   sim_slip_pos,
  output logic                   sim_slip_neg
);
  import t1lem_pkg::*;

  logic [7:0]  ctrl_r;          // Mode and test control
  logic [7:0]  line_r;          // Line interface control
  logic [3:0]  freeze_r;        // Freeze bits per counter
  logic [3:0]  freeze_d_r;      // Freeze bits last cycle
  logic [15:0] cnt_r [4];       // Live counters
  logic [15:0] buf_r [4];       // Read buffers
  logic [15:0] inc   [4];       // Increment per counter
  logic [2:0]  step_r;          // alarm_test_step
  logic        adv_d_r;         // Advance bit last cycle
  logic        short_r;         // tx_short_status
  logic        open_r;          // tx_open_status
  logic        tri_r;           // Outputs tristated
  logic [1:0]  short_cnt_r;     // Shorted pulses seen
  logic [7:0]  retry_cnt_r;     // Tristate hold periods
  logic [5:0]  zero_cnt_r;      // Transmitted zero run
  logic [4:0]  rx_zero_run_r;   // Received zero run
  logic        irq_r;           // Line change status
  logic        prbs_sync_r;     // PRBS synchroniser locked
  logic [5:0]  prbs_good_r;     // Good bits in a row
  logic [14:0] prbs_sh_r;       // PRBS shift register
  logic        sim_par_r;       // Every-second-bit toggle
  logic        sim_blk_done_r;  // One-shot block count in non-ESF
  logic        fe_seen_r;       // Framing error seen in this block
  logic [7:0]  rdata_r;         // Read data register

  wire adv      = ctrl_r[CTRL_ADV_BIT];
  wire esf      = ctrl_r[CTRL_ESF_BIT];
  wire [1:0] code = ctrl_r[CTRL_CODE_LSB +: 2];
  wire sim_on   = (step_r != 3'h0);

  // Step decode, used by several alarm outputs
  function automatic logic step_in(input logic [2:0] s,
                                   input logic [7:0] set);
    step_in = set[s];
  endfunction

  wire st_loss  = step_in(step_r, 8'h44); // Steps 2, 6 RULE8
  wire st_err   = step_in(step_r, 8'h26); // Steps 1, 2, 5 RULE8
  wire st_crc   = step_in(step_r, 8'h66); // Steps 1, 2, 5, 6
  wire st_blk   = esf ? st_crc : st_loss;

  // Simulated alarm outputs; idle steps force them low
  always_comb begin
    sim_frame_loss      = st_loss; // RULE10
    sim_multiframe_loss = st_loss;
    sim_loss_of_signal  = st_err & adv; // RULE9
    sim_all_ones        = step_in(step_r, 8'h66) & adv; // RULE9
    sim_slip_pos        = (step_r == 3'h1); // RULE8
    sim_slip_neg        = (step_r == 3'h5);
  end

  // Control registers written by software
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= RESET_BYTE;
      line_r <= RESET_BYTE;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == ADDR_CTRL) ctrl_r <= reg_wdata;
      if (reg_addr == ADDR_LINE) line_r <= reg_wdata;
    end
  end

  // Step counter advances on the advance bit's rising edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      step_r  <= 3'h0; // RULE23
      adv_d_r <= 1'b0;
    end else if (clk_en) begin
      adv_d_r <= adv;
      if (adv && !adv_d_r) step_r <= step_r + 3'h1; // RULE7 RULE12
    end
  end

  // Freeze bits: software sets, high byte read clears
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      freeze_r   <= 4'h0;
      freeze_d_r <= 4'h0;
    end else if (clk_en) begin
      freeze_d_r <= freeze_r;
      if (reg_wr && reg_addr == ADDR_FREEZE)
        freeze_r <= freeze_r | reg_wdata[3:0];
      else if (reg_rd) begin
        if (reg_addr == ADDR_FE_HI) freeze_r[0] <= 1'b0; // RULE21
        if (reg_addr == ADDR_CV_HI) freeze_r[1] <= 1'b0;
        if (reg_addr == ADDR_CR_HI) freeze_r[2] <= 1'b0;
        if (reg_addr == ADDR_EB_HI) freeze_r[3] <= 1'b0;
      end
    end
  end

  // Received zero run for excess-zero detection
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_zero_run_r <= 5'h0;
      sim_par_r     <= 1'b0;
    end else if (clk_en && rx_ev.rx_bit_valid) begin
      sim_par_r <= ~sim_par_r;
      if (!rx_ev.rx_zero) rx_zero_run_r <= 5'h0;
      else if (rx_zero_run_r != 5'h1F)
        rx_zero_run_r <= rx_zero_run_r + 5'h1;
    end
  end

  // Excess zero strobe at the first zero beyond the limit
  wire exz_hit = ctrl_r[CTRL_EXZ_BIT] && rx_ev.rx_bit_valid &&
                 rx_ev.rx_zero &&
                 ((code == CODE_B8ZS &&
                   rx_zero_run_r == 5'(EXZ_B8ZS)) || // RULE16
                  (code == CODE_AMI &&
                   rx_zero_run_r == 5'(EXZ_AMI)));    // RULE17
  wire sync     = rx_ev.frame_sync;
  wire crc_on   = esf && ctrl_r[CTRL_CRC6_BIT];

  // Increments for each counter, real or simulated
  always_comb begin
    inc[0] = 16'h0;
    inc[1] = 16'h0;
    inc[2] = 16'h0;
    inc[3] = 16'h0;
    if (sim_on) begin
      if (st_loss && sync && rx_ev.mf_end) begin
        inc[0] = 16'h2; // RULE15
      end
      if (st_err && rx_ev.rx_bit_valid && sim_par_r &&
          code[1]) inc[1] = 16'h1; // RULE15 RULE18
      if (st_crc && crc_on && rx_ev.mf_end) inc[2] = 16'h1;
      if (st_blk && sync && rx_ev.mf_end &&
          (esf || !sim_blk_done_r)) inc[3] = 16'h1; // RULE15
    end else begin
      if (sync && rx_ev.fbit_error) inc[0] = 16'h1; // RULE13
      if (code == CODE_B8ZS &&
          ((rx_ev.bpv && !rx_ev.subst_bpv) || exz_hit))
        inc[1] = 16'h1; // RULE16
      if (code == CODE_AMI && (rx_ev.bpv || exz_hit))
        inc[1] = 16'h1; // RULE17 RULE18
      if (crc_on && sync && rx_ev.mf_end && rx_ev.crc_error)
        inc[2] = 16'h1; // RULE19
      if (sync && rx_ev.mf_end &&
          (rx_ev.fbit_error || fe_seen_r ||
           (esf && rx_ev.crc_error)))
        inc[3] = 16'h1; // RULE20
    end
  end

  // Framing errors remembered until the block ends
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) fe_seen_r <= 1'b0;
    else if (clk_en) begin
      if (rx_ev.mf_end) fe_seen_r <= 1'b0; // RULE20
      else if (sync && rx_ev.fbit_error) fe_seen_r <= 1'b1;
    end
  end

  // Non-ESF simulated block counts only once per sequence
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) sim_blk_done_r <= 1'b0;
    else if (clk_en) begin
      if (!sim_on) sim_blk_done_r <= 1'b0;
      else if (inc[3] != 16'h0) sim_blk_done_r <= 1'b1;
    end
  end

  // Four counters with buffers
  for (genvar i = 0; i < 4; i++) begin : g_cnt
    wire [16:0] sum = {1'b0, cnt_r[i]} + {1'b0, inc[i]};
    wire        rst_fr = freeze_r[i] && !freeze_d_r[i];
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        cnt_r[i] <= 16'h0; // RULE23
        buf_r[i] <= 16'h0;
      end else if (clk_en) begin
        if (ctrl_r[CTRL_LATCH_BIT]) begin
          if (one_hz_tick) begin
            buf_r[i] <= cnt_r[i]; // RULE22
            cnt_r[i] <= inc[i];
          end else
            cnt_r[i] <= sum[16] ? CNT_MAX : sum[15:0]; // RULE14
        end else begin
          if (!freeze_r[i]) buf_r[i] <= cnt_r[i]; // RULE21
          if (rst_fr) cnt_r[i] <= 16'h0;
          else cnt_r[i] <= sum[16] ? CNT_MAX : sum[15:0]; // RULE14
        end
      end
    end
  end

  // Transmit short detection and auto tristate
  wire ternary = !line_r[LINE_DRS_BIT];
  wire hold_st = line_r[LINE_XLT_BIT];
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      short_r     <= 1'b0;
      tri_r       <= 1'b0;
      short_cnt_r <= 2'h0;
      retry_cnt_r <= 8'h0;
    end else if (clk_en && tx_ev.pulse_tick) begin
      if (tri_r) begin
        // Hold high impedance, then recheck the limiter
        if (retry_cnt_r == 8'(RETRY_PERIODS - 1)) begin
          tri_r       <= 1'b0; // RULE3
          retry_cnt_r <= 8'h0;
        end else retry_cnt_r <= retry_cnt_r + 8'h1;
      end else if (ternary && tx_ev.short_sense) begin
        if (short_cnt_r != 2'(SHORT_PULSES)) short_cnt_r <= short_cnt_r + 2'h1;
        else begin
          if (!hold_st) short_r <= 1'b1; // RULE2 RULE6
          tri_r <= !line_r[LINE_AUTO_TRISTATE_DISABLE_BIT]; // RULE3
        end
      end else begin
        short_cnt_r <= 2'h0;
        if (!hold_st) short_r <= 1'b0; // RULE4 RULE6
      end
    end
  end

  // Transmit open detection by zero run
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      open_r     <= 1'b0;
      zero_cnt_r <= 6'h0;
    end else if (clk_en && tx_ev.pulse_tick) begin
      if (tx_ev.pulse_sent) begin
        zero_cnt_r <= 6'h0;
        if (!hold_st) open_r <= 1'b0; // RULE5 RULE6
      end else begin
        if (zero_cnt_r != 6'(OPEN_ZEROS)) zero_cnt_r <= zero_cnt_r + 6'h1;
        if (zero_cnt_r >= 6'(OPEN_ZEROS - 1) && !hold_st)
          open_r <= 1'b1; // RULE5
      end
    end
  end

  // Line change status: set wins over read clear
  logic short_d_r;
  logic open_d_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_r     <= 1'b0;
      short_d_r <= 1'b0;
      open_d_r  <= 1'b0;
    end else if (clk_en) begin
      short_d_r <= short_r;
      open_d_r  <= open_r;
      if ((short_r != short_d_r) || (open_r && !open_d_r))
        irq_r <= 1'b1; // RULE4 RULE5
      else if (reg_rd && reg_addr == ADDR_IRQ) irq_r <= 1'b0;
    end
  end

  // PRBS 2^15-1 self-sync checker with tolerant lock
  wire prbs_exp = prbs_sh_r[14] ^ prbs_sh_r[13];
  wire prbs_ok  = (rx_ev.rx_bit == prbs_exp) ||
                  (prbs_sh_r == 15'h0) || (prbs_sh_r == 15'h7FFF);
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prbs_sh_r   <= 15'h0;
      prbs_good_r <= 6'h0;
      prbs_sync_r <= 1'b0;
    end else if (clk_en) begin
      if (!ctrl_r[CTRL_PRBS_BIT]) begin
        prbs_good_r <= 6'h0;
        prbs_sync_r <= 1'b0;
      end else if (rx_ev.rx_bit_valid) begin
        prbs_sh_r <= {prbs_sh_r[13:0], rx_ev.rx_bit};
        // Once locked, errors neither clear the good count nor drop sync
        if (prbs_ok) begin
          if (prbs_good_r != 6'(PRBS_SYNC_BITS))
            prbs_good_r <= prbs_good_r + 6'h1;
          else prbs_sync_r <= 1'b1; // RULE1
        end else if (!prbs_sync_r) prbs_good_r <= 6'h0;
      end
    end
  end

  // Register read mux, data one cycle later
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) rdata_r <= RESET_BYTE;
    else if (clk_en && reg_rd) begin
      case (reg_addr)
        ADDR_RX_STATUS_ONE:
          rdata_r <= {5'h0, prbs_sync_r, short_r & ternary, open_r};
        ADDR_RX_STATUS_TWO: rdata_r <= {5'h0, step_r};
        ADDR_FE_LO:  rdata_r <= buf_r[0][7:0];
        ADDR_FE_HI:  rdata_r <= buf_r[0][15:8];
        ADDR_CV_LO:  rdata_r <= buf_r[1][7:0];
        ADDR_CV_HI:  rdata_r <= buf_r[1][15:8];
        ADDR_CR_LO:  rdata_r <= buf_r[2][7:0];
        ADDR_CR_HI:  rdata_r <= buf_r[2][15:8];
        ADDR_EB_LO:  rdata_r <= buf_r[3][7:0];
        ADDR_EB_HI:  rdata_r <= buf_r[3][15:8];
        ADDR_CTRL:   rdata_r <= ctrl_r;
        ADDR_FREEZE: rdata_r <= {4'h0, freeze_r};
        ADDR_LINE:   rdata_r <= line_r;
        ADDR_IRQ:    rdata_r <= {7'h0, irq_r};
        default:     rdata_r <= RESET_BYTE;
      endcase
    end
  end

  // Outputs
  always_comb begin
    reg_rdata          = rdata_r;
    tx_line_out_a_oe_n = tri_r; // RULE3
    tx_line_out_b_oe_n = tri_r;
    tx_line_change_irq = irq_r;
  end
endmodule
`default_nettype wire

// ### t1lem_pkg.sv
// Package for the T1 line error monitor: register map, fields, constants.
// Assumes an 8-bit register port with byte-wide registers.
`default_nettype none
package t1lem_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_RX_STATUS_ONE = 8'h00; // Line and PRBS status
  localparam logic [7:0] ADDR_RX_STATUS_TWO = 8'h01; // Alarm test step
  localparam logic [7:0] ADDR_FE_LO  = 8'h02; // Framing errors low
  localparam logic [7:0] ADDR_FE_HI  = 8'h03; // Framing errors high
  localparam logic [7:0] ADDR_CV_LO  = 8'h04; // Code violations low
  localparam logic [7:0] ADDR_CV_HI  = 8'h05; // Code violations high
  localparam logic [7:0] ADDR_CR_LO  = 8'h06; // CRC errors low
  localparam logic [7:0] ADDR_CR_HI  = 8'h07; // CRC errors high
  localparam logic [7:0] ADDR_EB_LO  = 8'h08; // Errored blocks low
  localparam logic [7:0] ADDR_EB_HI  = 8'h09; // Errored blocks high
  localparam logic [7:0] ADDR_CTRL   = 8'h0A; // Mode and test control
  localparam logic [7:0] ADDR_FREEZE = 8'h0B; // Counter freeze control
  localparam logic [7:0] ADDR_LINE   = 8'h0C; // Line interface control
  localparam logic [7:0] ADDR_IRQ    = 8'h0D; // Line change status
  // Control register fields
  localparam int CTRL_LATCH_BIT  = 0; // counter_latch_mode
  localparam int CTRL_ADV_BIT    = 1; // alarm_test_advance
  localparam int CTRL_EXZ_BIT    = 2; // excess_zeros_enable
  localparam int CTRL_CODE_LSB   = 3; // line_code_select, 2 bits
  localparam int CTRL_ESF_BIT    = 5; // ESF format
  localparam int CTRL_CRC6_BIT   = 6; // CRC6 enabled
  localparam int CTRL_PRBS_BIT   = 7; // prbs_monitor_enable
  // Line control fields
  localparam int LINE_DRS_BIT    = 0; // dual_rail_select
  localparam int LINE_AUTO_TRISTATE_DISABLE_BIT  = 1; // auto_tristate_disable
  localparam int LINE_XLT_BIT    = 2; // tx_line_tristate
  // Line codes
  localparam logic [1:0] CODE_NRZ  = 2'h0;
  localparam logic [1:0] CODE_CMI  = 2'h1;
  localparam logic [1:0] CODE_AMI  = 2'h2;
  localparam logic [1:0] CODE_B8ZS = 2'h3;
  // Counts
  localparam int SHORT_PULSES    = 3;   // Shorted pulses counted before the one that confirms a short
  localparam int RETRY_PERIODS   = 128; // Tristate hold time
  localparam int OPEN_ZEROS      = 32;  // Zeros to flag an open
  localparam int EXZ_B8ZS        = 7;   // Zero run limit, B8ZS
  localparam int EXZ_AMI         = 15;  // Zero run limit, AMI
  localparam int PRBS_SYNC_BITS  = 32;  // Good bits counted before the one that declares sync
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Receive-side event inputs grouped together
  typedef struct packed {
    logic frame_sync;   // Frame synchronous state
    logic fbit_error;   // Wrong framing bit
    logic bpv;          // Bipolar violation
    logic subst_bpv;    // Violation belonging to zero substitution
    logic rx_zero;      // Received bit was zero (one per bit)
    logic rx_bit_valid; // Receive bit strobe
    logic rx_bit;       // Received data bit
    logic mf_end;       // Multiframe boundary
    logic crc_error;    // CRC error at multiframe end
  } t1lem_rx_t;
  // Transmit-side line observations
  typedef struct packed {
    logic pulse_tick;   // One pulse period elapsed
    logic pulse_sent;   // Pulse (mark) sent this period
    logic short_sense;  // Current limiter reports short
  } t1lem_tx_t;
endpackage
`default_nettype wire

// ### t1lem_monitor_asserts.sv
// Checker for the line error monitor, bound to its top module.
// Assumes clk_en stays high; mirrors the control bits it needs.
`default_nettype none
module t1lem_asserts
  import t1lem_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 resetn,
  input wire logic [7:0]           reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_rdata,
  input wire t1lem_pkg::t1lem_tx_t tx_ev,
  input wire logic                 tx_line_out_a_oe_n,
  input wire logic                 tx_line_out_b_oe_n,
  input wire logic                 sim_frame_loss,
  input wire logic                 sim_multiframe_loss,
  input wire logic                 sim_loss_of_signal,
  input wire logic                 sim_slip_pos,
  input wire logic                 sim_slip_neg
);
  logic [2:0] step_r; // Mirrored test step
  logic       adv_r;  // Mirrored advance bit
  logic       adv_d_r; // Advance bit last cycle
  logic [7:0] line_r; // Mirrored line control
  logic [7:0] hi_r;   // Pulse ticks spent tristated
  // Mirror of control writes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      step_r <= 3'h0;
      adv_r  <= 1'b0;
      adv_d_r <= 1'b0;
      line_r <= 8'h00;
    end else begin
      adv_d_r <= adv_r;
      step_r  <= step_r + 3'(adv_r && !adv_d_r);
      if (reg_wr && reg_addr == ADDR_LINE) line_r <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_CTRL)
        adv_r <= reg_wdata[CTRL_ADV_BIT];
    end
  end
  // Ticks counted while the outputs float
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn || !tx_line_out_a_oe_n) begin
      hi_r <= 8'h00;
    end else if (tx_ev.pulse_tick && hi_r != 8'hFF) begin
      hi_r <= hi_r + 8'h01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Read of a place outside the map
  sequence s_bad_read;
    reg_rd && reg_addr > ADDR_IRQ;
  endsequence
  a_reset_clear: assert property (
    $rose(resetn) |-> !tx_line_out_a_oe_n && reg_rdata == 8'h00)
    else $error("line or read data not clear after reset");
  a_unmapped_zero: assert property (s_bad_read |=> reg_rdata == 8'h00)
    else $error("unmapped read gave nonzero data");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_oe_paired: assert property (
    tx_line_out_a_oe_n == tx_line_out_b_oe_n)
    else $error("line outputs enabled apart");
  a_retry_bound: assert property (hi_r <= 8'h82)
    else $error("tristate held past retry time");
  a_hold_min: assert property (
    $fell(tx_line_out_a_oe_n) |-> hi_r >= 8'h7E)
    else $error("outputs re-enabled too early");
  a_auto_off: assert property (
    $rose(tx_line_out_a_oe_n) |-> line_r[2:0] == 3'h0)
    else $error("tristate while disabled or dual rail");
  a_sim_frame: assert property (
    sim_frame_loss || sim_multiframe_loss |-> step_r inside {2, 6})
    else $error("frame loss simulated at wrong step");
  a_sim_los: assert property (
    sim_loss_of_signal == (adv_r && step_r inside {1, 2, 5}))
    else $error("signal loss simulation wrong");
  a_sim_slips: assert property (
    sim_slip_pos || sim_slip_neg |-> step_r == {sim_slip_neg, 2'h1})
    else $error("slip simulated at wrong step");
  a_quiet_steps: assert property (
    step_r inside {0, 3, 4, 7} |-> !(sim_frame_loss || sim_slip_pos
    || sim_slip_neg || sim_loss_of_signal))
    else $error("simulated flag pending at quiet step");
endmodule
bind t1lem_monitor t1lem_asserts u_chk (.*);
`default_nettype wire

// ### t1lem_line_model.sv
// Transmit line model: pulse periods, marks and a shorted pair.
// Assumes one pulse period every two core_clk cycles.
`default_nettype none
module t1lem_line_model
  import t1lem_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                short_on,
  input  wire logic                marks_on,
  output var t1lem_pkg::t1lem_tx_t tx_ev
);
  logic div_r; // Pulse period divider
  // Short sensed only while marks drive current
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= 1'b0;
      tx_ev <= '0;
    end else begin
      div_r             <= ~div_r;
      tx_ev.pulse_tick  <= div_r;
      tx_ev.pulse_sent  <= div_r & marks_on;
      tx_ev.short_sense <= div_r & marks_on & short_on;
    end
  end
endmodule
`default_nettype wire

// ### t1lem_monitor_tb_top.sv
// Bench for the line error monitor: bus tasks and scenarios.
// Assumes the line model on the transmit side, one clock.
`default_nettype none
module t1lem_monitor_tb_top import t1lem_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [8:0] M_FE = 9'h080, M_BPV = 9'h040, M_SUB = 9'h060;
  localparam logic [8:0] M_ZERO = 9'h018, M_ONE = 9'h00C;
  localparam logic [8:0] M_MF = 9'h002, M_CRC = 9'h003;
  logic       core_clk = 1'b0, resetn = 1'b0; // Clock, reset
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata; // Bus
  logic       reg_wr = 1'b0, reg_rd = 1'b0, one_hz_tick = 1'b0;
  logic       short_on = 1'b0, marks_on = 1'b1, sync = 1'b0;
  t1lem_rx_t  rx_ev = '0; // Receive events
  t1lem_tx_t  tx_ev;      // Line observations
  logic       oe_a, oe_b, irq, s_fl, s_mf, s_los, s_ais, s_sp, s_sn;
  int         failures = 0, samples_checked = 0;
  always #5 core_clk = ~core_clk;
  t1lem_monitor uut (.core_clk(core_clk), .resetn(resetn), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata), .rx_ev(rx_ev), .tx_ev(tx_ev),
    .one_hz_tick(one_hz_tick), .tx_line_out_a_oe_n(oe_a),
    .tx_line_out_b_oe_n(oe_b), .tx_line_change_irq(irq),
    .sim_frame_loss(s_fl), .sim_multiframe_loss(s_mf),
    .sim_loss_of_signal(s_los), .sim_all_ones(s_ais),
    .sim_slip_pos(s_sp), .sim_slip_neg(s_sn));
  t1lem_line_model u_line (.core_clk(core_clk), .resetn(resetn),
    .short_on(short_on), .marks_on(marks_on), .tx_ev(tx_ev));
  // Verdict and end of run
  task automatic close_out();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Low byte, then high byte
  task automatic rd16(logic [7:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 8'h01, v[15:8]);
  endtask
  // Freeze, then high read: counter restarts from zero
  task automatic clr(logic [7:0] a);
    logic [15:0] v;
    wr(ADDR_FREEZE, 8'h01 << ((a - 8'h02) >> 1));
    rd16(a, v);
  endtask
  task automatic pulse(logic [8:0] m, int n);
    repeat (n) begin
      @(posedge core_clk);
      rx_ev <= t1lem_rx_t'(m | {sync, 8'h00});
      @(posedge core_clk);
      rx_ev <= t1lem_rx_t'({sync, 8'h00});
    end
  endtask
  task automatic sec();
    @(posedge core_clk);
    one_hz_tick <= 1'b1;
    @(posedge core_clk);
    one_hz_tick <= 1'b0;
  endtask
  task automatic wait_oe(logic lvl, int n);
    for (int k = 0; k < n && oe_a !== lvl; k++) begin
      @(posedge core_clk);
      #1;
    end
    chk("oe_n", lvl, oe_a);
  endtask
  task automatic t_reset();
    logic [7:0] d;
    for (int a = 0; a < 10; a++) begin
      rd(a[7:0], d);
      chk("reset value", 8'h00, d);
    end
    wr(ADDR_FE_LO, 8'hFF);
    rd(ADDR_FE_LO, d);
    chk("read only", 8'h00, d);
    rd(8'h40, d);
    chk("unmapped", 8'h00, d);
    wr(ADDR_CTRL, 8'h80);
    pulse(M_ZERO, 40);
    rd(ADDR_RX_STATUS_ONE, d);
    chk("prbs sync", 8'h04, d & 8'h04);
  endtask
  task automatic t_counts();
    logic [15:0] v;
    wr(ADDR_CTRL, 8'h00);
    sync = 1'b1;
    pulse(M_FE, 5);
    sync = 1'b0;
    pulse(M_FE, 2);
    rd16(ADDR_FE_LO, v);
    chk("fe count", 16'h0005, v);
    sync = 1'b1;
    wr(ADDR_FREEZE, 8'h01);
    pulse(M_FE, 3);
    rd(ADDR_FREEZE, v[7:0]);
    chk("freeze set", 8'h01, v[7:0] & 8'h01);
    rd16(ADDR_FE_LO, v);
    chk("frozen", 16'h0005, v);
    rd(ADDR_FREEZE, v[7:0]);
    chk("freeze clear", 8'h00, v[7:0] & 8'h01);
    rd16(ADDR_FE_LO, v);
    chk("restarted", 16'h0003, v);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL, 8'h04 | 8'(c << CTRL_CODE_LSB));
      clr(ADDR_CV_LO);
      pulse(M_ONE, 1);
      pulse(M_BPV, 3);
      pulse(M_SUB, 2);
      pulse(M_ZERO, (c == 2) ? 16 : 8);
      pulse(M_ONE, 1);
      rd16(ADDR_CV_LO, v);
      chk("cv", (c == 2) ? 6 : (c == 3) ? 4 : 0, v);
    end
  endtask
  task automatic t_crc();
    logic [15:0] v;
    wr(ADDR_CTRL, 8'h60);
    clr(ADDR_CR_LO);
    clr(ADDR_EB_LO);
    pulse(M_CRC, 3);
    sync = 1'b0;
    pulse(M_CRC, 2);
    sync = 1'b1;
    rd16(ADDR_EB_LO, v);
    chk("eb esf", 16'h0003, v);
    wr(ADDR_CTRL, 8'h20);
    pulse(M_CRC, 1);
    rd16(ADDR_CR_LO, v);
    chk("crc", 16'h0003, v);
    wr(ADDR_CTRL, 8'h00);
    clr(ADDR_EB_LO);
    pulse(M_FE, 2);
    pulse(M_MF, 2);
    rd16(ADDR_EB_LO, v);
    chk("eb block", 16'h0001, v);
    wr(ADDR_CTRL, 8'h01);
    sec();
    pulse(M_FE, 4);
    sec();
    pulse(M_FE, 2);
    rd16(ADDR_FE_LO, v);
    chk("latched", 16'h0004, v);
    sec();
    rd16(ADDR_FE_LO, v);
    chk("next second", 16'h0002, v);
  endtask
  task automatic t_line();
    logic [7:0] d;
    short_on = 1'b1;
    wait_oe(1'b1, 40);
    rd(ADDR_RX_STATUS_ONE, d);
    chk("short", 8'h02, d & 8'h02);
    chk("change irq", 1'b1, irq);
    wait_oe(1'b0, 300);
    wait_oe(1'b1, 40);
    short_on = 1'b0;
    wait_oe(1'b0, 300);
    repeat (300) @(posedge core_clk);
    chk("stays on", 1'b0, oe_a);
    rd(ADDR_IRQ, d);
    rd(ADDR_RX_STATUS_ONE, d);
    chk("short gone", 8'h00, d & 8'h02);
    wr(ADDR_LINE, 8'h02);
    short_on = 1'b1;
    repeat (40) @(posedge core_clk);
    chk("no auto tristate", 1'b0, oe_a);
    short_on = 1'b0;
    for (int x = 0; x < 2; x++) begin
      wr(ADDR_LINE, x ? 8'h04 : 8'h00);
      marks_on = 1'b0;
      repeat (80) @(posedge core_clk);
      rd(ADDR_RX_STATUS_ONE, d);
      chk("open", x ? 8'h00 : 8'h01, d & 8'h01);
      marks_on = 1'b1;
      repeat (6) @(posedge core_clk);
      rd(ADDR_RX_STATUS_ONE, d);
      chk("open gone", 8'h00, d & 8'h01);
    end
  endtask
  task automatic t_sim();
    logic [7:0] d;
    logic [2:0] st;
    for (int i = 1; i <= 8; i++) begin
      st = i[2:0];
      wr(ADDR_CTRL, 8'h02);
      rd(ADDR_RX_STATUS_TWO, d);
      chk("step", {5'h00, st}, d & 8'h07);
      chk("los", st inside {1, 2, 5}, s_los);
      chk("ais", st inside {1, 2, 5, 6}, s_ais);
      chk("frame", {2{st inside {2, 6}}}, {s_fl, s_mf});
      chk("slips", {st == 3'h1, st == 3'h5}, {s_sp, s_sn});
      wr(ADDR_CTRL, 8'h00);
      chk("los released", 1'b0, s_los);
    end
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_counts();
    t_crc();
    t_line();
    t_sim();
    close_out();
  end
  // Watchdog against a hung wait
  initial begin
    #500000;
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
